// ---- common/uscs_pkg.sv ----
`default_nettype none
package uscs_pkg;
   localparam logic [15:0] RX_BUF_ADDR = 16'hff51;
   localparam logic [15:0] TX_BUF_ADDR = 16'hff52;
   localparam logic [15:0] RX_ERR_ADDR = 16'hff53;
   localparam logic [15:0] TX_STAT_ADDR = 16'hff55;
   localparam logic [15:0] CKS_ADDR = 16'hff56;

   localparam logic [7:0] RX_ERR_RST = 8'h00;
   localparam logic [7:0] TX_STAT_RST = 8'h00;
   localparam logic [3:0] CKS_RST = 4'h0;
   localparam logic [7:0] RX_BUF_RST = 8'hff;
   localparam logic [7:0] TX_BUF_RST = 8'hff;
   localparam logic [7:0] UNMAPPED_VAL = 8'h00;

   localparam int PE_POS = 2;
   localparam int FE_POS = 1;
   localparam int OVE_POS = 0;
   localparam int TXBF_POS = 1;
   localparam int TXSF_POS = 0;
   localparam int ERR_W = 3;
   localparam int CKS_SEL_W = 4;

   localparam logic [3:0] CKS_DIV_MAX = 4'ha;
   localparam logic [3:0] CKS_TIMER = 4'hb;
   localparam int PRESCALE_W = 10;
   localparam int FRAME_W = 12;

   typedef enum logic [1:0] {
      PAR_NONE = 2'b00,
      PAR_ZERO = 2'b01,
      PAR_ODD = 2'b10,
      PAR_EVEN = 2'b11
   } uscs_par_t;

   typedef enum logic [2:0] {
      RX_IDLE = 3'b000,
      RX_START = 3'b001,
      RX_DATA = 3'b010,
      RX_PAR = 3'b011,
      RX_STOP = 3'b100
   } uscs_rx_st_t;

   typedef struct packed {
      logic power;
      logic tx_en;
      logic rx_en;
      uscs_par_t parity;
      logic char8;
      logic stop2;
   } uscs_mode_t;

   typedef struct packed {
      logic [15:0] addr;
      logic rd;
      logic wr;
      logic [7:0] wdata;
   } uscs_bus_req_t;
endpackage
`default_nettype wire

// ---- rtl/uscs_clk_sel.sv ----
`timescale 1ns/1ps
`default_nettype none
module uscs_clk_sel #(
   parameter int PRE_W = uscs_pkg::PRESCALE_W
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic run_in,
   input wire logic [3:0] sel_in,
   input wire logic timer_in,
   input wire logic [7:0] div_k_in,
   output logic half_tick_out
);
   logic [PRE_W-1:0] pre_ff;
   logic timer_q_ff;
   logic [7:0] div_ff;
   logic half_ff;
   wire [PRE_W:0] mask_w;
   wire pre_tick;
   wire timer_edge;
   wire base_tick;
   wire div_end;

   // Power-of-two prescaler; a code's tick is all low bits set
   assign mask_w = ((PRE_W+1)'(1) << sel_in) - (PRE_W+1)'(1);
   assign pre_tick = (pre_ff & mask_w[PRE_W-1:0]) == mask_w[PRE_W-1:0];
   assign timer_edge = timer_in & ~timer_q_ff;
   // Prohibited codes give no tick at all rather than a random rate
   assign base_tick = (sel_in <= uscs_pkg::CKS_DIV_MAX) ? pre_tick :
                      (sel_in == uscs_pkg::CKS_TIMER) ? timer_edge : 1'b0;
   assign div_end = div_ff == (div_k_in - 8'h01);
   assign half_tick_out = half_ff;

   always_ff @(posedge clk_in) begin
      if (!rst_n_in || !run_in) begin
         pre_ff <= '0;
         timer_q_ff <= 1'b0;
         div_ff <= 8'h00;
         half_ff <= 1'b0;
      end else begin
         pre_ff <= pre_ff + PRE_W'(1);
         timer_q_ff <= timer_in;
         half_ff <= base_tick & div_end;
         if (base_tick) begin
            div_ff <= div_end ? 8'h00 : div_ff + 8'h01;
         end
      end
   end

   a_tick_cause: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      half_tick_out |-> $past(base_tick)) else $error("half tick without base tick");
   a_tick_spacing: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      half_tick_out && run_in && div_k_in > 8'h01 && $stable(div_k_in) |=> !half_tick_out)
      else $error("divider ticks back to back");
endmodule
`default_nettype wire

// ---- rtl/uscs_tx_shift.sv ----
`timescale 1ns/1ps
`default_nettype none
module uscs_tx_shift #(
   parameter int FW = uscs_pkg::FRAME_W
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic clr_in,
   input wire logic half_tick_in,
   input wire logic buf_full_in,
   input wire logic [7:0] buf_data_in,
   input wire uscs_pkg::uscs_mode_t mode_in,
   output logic take_out,
   output logic busy_out,
   output logic txd_out
);
   logic [FW-1:0] sh_ff;
   logic [FW-1:0] frame;
   logic [3:0] left_ff;
   logic [3:0] nbits;
   logic ph_ff;
   logic busy_ff;
   logic pbit;
   wire [7:0] chr;
   wire par_on;
   wire bit_end;
   wire last;

   assign chr = mode_in.char8 ? buf_data_in : {1'b0, buf_data_in[6:0]};
   assign par_on = mode_in.parity != uscs_pkg::PAR_NONE;
   assign bit_end = busy_ff & half_tick_in & ph_ff;
   assign last = bit_end & (left_ff == 4'h1);
   // Reload on the last half tick so frames follow with no idle bit
   assign take_out = ~clr_in & buf_full_in & (~busy_ff | last);
   assign busy_out = busy_ff;
   assign txd_out = busy_ff ? sh_ff[0] : 1'b1;

   always_comb begin
      frame = '1;
      frame[0] = 1'b0;
      case (mode_in.parity)
         uscs_pkg::PAR_ODD: pbit = ~^chr;
         uscs_pkg::PAR_EVEN: pbit = ^chr;
         default: pbit = 1'b0;
      endcase
      if (mode_in.char8) begin
         frame[8:1] = buf_data_in;
      end else begin
         frame[7:1] = buf_data_in[6:0];
      end
      if (par_on) begin
         frame[mode_in.char8 ? 9 : 8] = pbit;
      end
      nbits = 4'h1 + (mode_in.char8 ? 4'h8 : 4'h7) + {3'h0, par_on} +
              (mode_in.stop2 ? 4'h2 : 4'h1);
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in || clr_in) begin
         sh_ff <= '1;
         left_ff <= 4'h0;
         ph_ff <= 1'b0;
         busy_ff <= 1'b0;
      end else if (take_out) begin
         sh_ff <= frame;
         left_ff <= nbits;
         ph_ff <= 1'b0;
         busy_ff <= 1'b1;
      end else if (busy_ff && half_tick_in) begin
         ph_ff <= ~ph_ff;
         if (bit_end) begin
            sh_ff <= {1'b1, sh_ff[FW-1:1]};
            left_ff <= left_ff - 4'h1;
            busy_ff <= ~last;
         end
      end
   end

   a_b2b_reload: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      last && buf_full_in && !clr_in |=> busy_out && txd_out == 1'b0)
      else $error("back to back frame not started");
   a_idle_high: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !busy_out |-> txd_out && sh_ff == '1) else $error("line low while idle");
endmodule
`default_nettype wire

// ---- rtl/uscs_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module uscs_top (
   input wire logic CLK_IN,
   input wire logic RST_N_IN,
   input wire uscs_pkg::uscs_bus_req_t BUS_IN,
   input wire uscs_pkg::uscs_mode_t MODE_IN,
   input wire logic [7:0] DIV_K_IN,
   input wire logic COMPANION_TIMER_IN,
   input wire logic RXD_IN,
   output logic [7:0] RDATA_OUT,
   output logic RVALID_OUT,
   output logic WAIT_OUT,
   output logic TXD_OUT
);
   logic [uscs_pkg::ERR_W-1:0] err_ff;
   logic [uscs_pkg::ERR_W-1:0] err_set;
   logic txbf_ff;
   logic [3:0] cks_ff;
   logic [7:0] txb_ff;
   logic [7:0] rxb_ff;
   logic rx_full_ff;
   logic [7:0] rdata_ff;
   logic rvalid_ff;
   logic wait_ff;
   logic txd_ff;

   uscs_pkg::uscs_rx_st_t rx_st_ff;
   uscs_pkg::uscs_rx_st_t nxt_rx_st;
   logic [3:0] rx_cnt_ff;
   logic [3:0] nxt_rx_cnt;
   logic [7:0] rx_sh_ff;
   logic [7:0] nxt_rx_sh;
   logic rx_pbit_ff;
   logic nxt_rx_pbit;
   logic rx_ph_ff;
   logic rx_done;

   wire half_tick;
   wire tx_take;
   wire tx_busy;
   wire tx_txd;

   // Bus decode; requests during a wait cycle are ignored
   wire bus_ok;
   wire rd_rxb;
   wire wr_txb;
   wire rd_txb;
   wire rd_err;
   wire rd_txs;
   wire rd_cks;
   wire wr_cks;
   wire [7:0] rd_val;

   assign bus_ok = ~wait_ff;
   assign rd_rxb = bus_ok & BUS_IN.rd & (BUS_IN.addr == uscs_pkg::RX_BUF_ADDR);
   assign rd_txb = bus_ok & BUS_IN.rd & (BUS_IN.addr == uscs_pkg::TX_BUF_ADDR);
   assign wr_txb = bus_ok & BUS_IN.wr & (BUS_IN.addr == uscs_pkg::TX_BUF_ADDR);
   assign rd_err = bus_ok & BUS_IN.rd & (BUS_IN.addr == uscs_pkg::RX_ERR_ADDR);
   assign rd_txs = bus_ok & BUS_IN.rd & (BUS_IN.addr == uscs_pkg::TX_STAT_ADDR);
   assign rd_cks = bus_ok & BUS_IN.rd & (BUS_IN.addr == uscs_pkg::CKS_ADDR);
   assign wr_cks = bus_ok & BUS_IN.wr & (BUS_IN.addr == uscs_pkg::CKS_ADDR);

   // Disable conditions act as synchronous clears of the status
   wire rx_off;
   wire tx_off;
   assign rx_off = ~MODE_IN.power | ~MODE_IN.rx_en;
   assign tx_off = ~MODE_IN.power | ~MODE_IN.tx_en;

   wire [7:0] tx_stat;
   assign tx_stat = {6'h00, txbf_ff, tx_busy};

   assign rd_val = rd_rxb ? rxb_ff :
                   rd_txb ? txb_ff :
                   rd_err ? {5'h00, err_ff} :
                   rd_txs ? tx_stat :
                   rd_cks ? {4'h0, cks_ff} :
                   uscs_pkg::UNMAPPED_VAL;

   uscs_clk_sel u_clk_sel (
      .clk_in(CLK_IN),
      .rst_n_in(RST_N_IN),
      .run_in(MODE_IN.power),
      .sel_in(cks_ff),
      .timer_in(COMPANION_TIMER_IN),
      .div_k_in(DIV_K_IN),
      .half_tick_out(half_tick)
   );

   uscs_tx_shift u_tx (
      .clk_in(CLK_IN),
      .rst_n_in(RST_N_IN),
      .clr_in(tx_off),
      .half_tick_in(half_tick),
      .buf_full_in(txbf_ff),
      .buf_data_in(txb_ff),
      .mode_in(MODE_IN),
      .take_out(tx_take),
      .busy_out(tx_busy),
      .txd_out(tx_txd)
   );

   // Receive framing, sampled at mid-bit on every second half tick
   wire rx_sample;
   wire par_on;
   wire par_chk;
   wire [7:0] rx_data;
   wire [3:0] rx_len;
   wire par_bad;
   wire rx_ovr;

   assign rx_sample = half_tick & ~rx_ph_ff & (rx_st_ff != uscs_pkg::RX_IDLE);
   assign par_on = MODE_IN.parity != uscs_pkg::PAR_NONE;
   // Zero parity still expects the bit but never judges it
   assign par_chk = MODE_IN.parity[1];
   assign rx_len = MODE_IN.char8 ? 4'h8 : 4'h7;
   assign rx_data = MODE_IN.char8 ? rx_sh_ff : {1'b0, rx_sh_ff[7:1]};
   assign par_bad = par_chk & ((^{rx_data, rx_pbit_ff}) ==
                    (MODE_IN.parity == uscs_pkg::PAR_EVEN));
   // A same-cycle buffer read frees the buffer, so no overrun then
   assign rx_ovr = rx_full_ff & ~rd_rxb;

   always_comb begin
      nxt_rx_st = rx_st_ff;
      nxt_rx_cnt = rx_cnt_ff;
      nxt_rx_sh = rx_sh_ff;
      nxt_rx_pbit = rx_pbit_ff;
      rx_done = 1'b0;
      case (rx_st_ff)
         uscs_pkg::RX_IDLE: begin
            if (half_tick && !RXD_IN) begin
               nxt_rx_st = uscs_pkg::RX_START;
            end
         end
         uscs_pkg::RX_START: begin
            nxt_rx_cnt = 4'h0;
            if (rx_sample) begin
               nxt_rx_st = RXD_IN ? uscs_pkg::RX_IDLE : uscs_pkg::RX_DATA;
            end
         end
         uscs_pkg::RX_DATA: begin
            if (rx_sample) begin
               nxt_rx_sh = {RXD_IN, rx_sh_ff[7:1]};
               nxt_rx_cnt = rx_cnt_ff + 4'h1;
               if (rx_cnt_ff == rx_len - 4'h1) begin
                  nxt_rx_st = par_on ? uscs_pkg::RX_PAR : uscs_pkg::RX_STOP;
               end
            end
         end
         uscs_pkg::RX_PAR: begin
            if (rx_sample) begin
               nxt_rx_pbit = RXD_IN;
               nxt_rx_st = uscs_pkg::RX_STOP;
            end
         end
         uscs_pkg::RX_STOP: begin
            // Back to idle after the first stop bit; a second one is idle line
            if (rx_sample) begin
               rx_done = 1'b1;
               nxt_rx_st = uscs_pkg::RX_IDLE;
            end
         end
         default: begin
            nxt_rx_st = uscs_pkg::RX_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN || rx_off) begin
         rx_st_ff <= uscs_pkg::RX_IDLE;
         rx_cnt_ff <= 4'h0;
         rx_sh_ff <= 8'h00;
         rx_pbit_ff <= 1'b0;
         rx_ph_ff <= 1'b0;
      end else begin
         rx_st_ff <= nxt_rx_st;
         rx_cnt_ff <= nxt_rx_cnt;
         rx_sh_ff <= nxt_rx_sh;
         rx_pbit_ff <= nxt_rx_pbit;
         rx_ph_ff <= (rx_st_ff == uscs_pkg::RX_IDLE) ? 1'b0 : rx_ph_ff ^ half_tick;
      end
   end

   // Receive buffer, written at the same completion that updates the flags
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN || !MODE_IN.power) begin
         rxb_ff <= uscs_pkg::RX_BUF_RST;
         rx_full_ff <= 1'b0;
      end else if (rx_done && !rx_ovr) begin
         rxb_ff <= rx_data;
         rx_full_ff <= 1'b1;
      end else if (rd_rxb) begin
         rx_full_ff <= 1'b0;
      end
   end

   assign err_set[uscs_pkg::PE_POS] = rx_done & par_bad;
   assign err_set[uscs_pkg::FE_POS] = rx_done & ~RXD_IN;
   assign err_set[uscs_pkg::OVE_POS] = rx_done & rx_ovr;

   // A new error in the read cycle survives the clear-on-read
   for (genvar i = 0; i < uscs_pkg::ERR_W; i++) begin : g_err
      always_ff @(posedge CLK_IN) begin
         if (!RST_N_IN || rx_off) begin
            err_ff[i] <= uscs_pkg::RX_ERR_RST[i];
         end else if (err_set[i]) begin
            err_ff[i] <= 1'b1;
         end else if (rd_err) begin
            err_ff[i] <= 1'b0;
         end
      end
   end

   // Transmit buffer and its full flag; a write wins over the move
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN || tx_off) begin
         txbf_ff <= uscs_pkg::TX_STAT_RST[uscs_pkg::TXBF_POS];
      end else if (wr_txb) begin
         txbf_ff <= 1'b1;
      end else if (tx_take) begin
         txbf_ff <= 1'b0;
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         txb_ff <= uscs_pkg::TX_BUF_RST;
         cks_ff <= uscs_pkg::CKS_RST;
      end else begin
         if (wr_txb) begin
            txb_ff <= BUS_IN.wdata;
         end
         if (wr_cks) begin
            cks_ff <= BUS_IN.wdata[uscs_pkg::CKS_SEL_W-1:0];
         end
      end
   end

   // Read answer: one cycle later, or two with a wait for error status
   always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
         rdata_ff <= 8'h00;
         rvalid_ff <= 1'b0;
         wait_ff <= 1'b0;
         txd_ff <= 1'b1;
      end else begin
         txd_ff <= tx_txd;
         wait_ff <= rd_err;
         rvalid_ff <= wait_ff | (bus_ok & BUS_IN.rd & ~rd_err);
         if (bus_ok && BUS_IN.rd) begin
            rdata_ff <= rd_val;
         end
      end
   end

   assign RDATA_OUT = rdata_ff;
   assign RVALID_OUT = rvalid_ff;
   assign WAIT_OUT = wait_ff;
   assign TXD_OUT = txd_ff;

   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (!RST_N_IN);

   a_err_off_clear: assert property (rx_off |=> err_ff == 3'h0)
      else $error("error flags not cleared when disabled");
   a_err_upper_zero: assert property (rd_err |=> RDATA_OUT[7:3] == 5'h00)
      else $error("error status upper bits not zero");
   a_err_rd_clear: assert property (rd_err && !rx_done && !rx_off |=> err_ff == 3'h0)
      else $error("error flags survived a read");
   a_par_set: assert property (rx_done && par_bad && !rx_off |=> err_ff[2])
      else $error("parity flag not set");
   a_frame_set: assert property (rx_done && !RXD_IN && !rx_off |=> err_ff[1])
      else $error("framing flag not set");
   a_ovr_keep: assert property (rx_done && rx_ovr && !rx_off
      |=> err_ff[0] && $stable(rxb_ff))
      else $error("overrun handling wrong");
   a_zero_par: assert property (MODE_IN.parity == uscs_pkg::PAR_ZERO && !err_ff[2]
      |=> !err_ff[2])
      else $error("parity flag set in zero parity mode");
   a_err_wait: assert property (rd_err |=> WAIT_OUT && !RVALID_OUT ##1 !WAIT_OUT && RVALID_OUT)
      else $error("error read wait cycle wrong");
   a_tx_off_clear: assert property (tx_off |=> !txbf_ff && !tx_busy)
      else $error("transmit status not cleared");
   a_txbf_set: assert property (wr_txb && !tx_off |=> txbf_ff)
      else $error("buffer full not set on write");
   a_txbf_move: assert property (tx_take && !wr_txb |=> !txbf_ff && tx_busy)
      else $error("buffer move flags wrong");
   a_cks_read: assert property (rd_cks |=> RDATA_OUT == {4'h0, $past(cks_ff)})
      else $error("clock select readback wrong");
   a_rx_store: assert property (rx_done && !rx_ovr && MODE_IN.power
      |=> rx_full_ff && rxb_ff == $past(rx_data))
      else $error("receive buffer not updated at completion");
endmodule
`default_nettype wire

// ---- verif/uscs_node.sv ----
`timescale 1ns/1ps
`default_nettype none
module uscs_node (
   input wire logic clk_in,
   input wire logic txd_in,
   output logic rxd_out
);
   int bit_clk = 16;
   initial rxd_out = 1'b1;
   // Line rests high between frames, as a pulled-up wire would
   task automatic send(input logic [7:0] d, input logic par_on, input logic pb,
         input logic sb);
      logic [10:0] f;
      f = par_on ? {sb, pb, d, 1'b0} : {1'b1, sb, d, 1'b0};
      for (int i = 0; i < (par_on ? 11 : 10); i++) begin
         @(posedge clk_in) rxd_out <= f[i];
         repeat (bit_clk - 1) @(posedge clk_in);
      end
      @(posedge clk_in) rxd_out <= 1'b1;
   endtask
   task automatic until_lvl(input logic v, input int lim, output int n);
      n = 0;
      while (txd_in !== v && n < lim) begin
         @(negedge clk_in);
         n++;
      end
   endtask
   // Data bit 0 must be high, since the start bit length varies by up to a half bit
   task automatic recv(output logic [7:0] d, output int gap);
      int n;
      until_lvl(1'b0, 4000, n);
      until_lvl(1'b1, 200, n);
      d[0] = txd_in;
      repeat (bit_clk / 2) @(negedge clk_in);
      for (int j = 1; j < 9; j++) begin
         repeat (bit_clk) @(negedge clk_in);
         if (j < 8) d[j] = txd_in;
      end
      until_lvl(1'b0, 20, gap);
   endtask
   task automatic hi_width(output int w);
      int n;
      until_lvl(1'b0, 4000, n);
      until_lvl(1'b1, 200, n);
      until_lvl(1'b0, 2000, w);
   endtask
endmodule
`default_nettype wire

// ---- verif/uart_status_and_clock_select_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module uart_status_and_clock_select_bench;
   logic clk, rst_n, tmr, rxd, rvalid, waitp, txd;
   logic [7:0] div_k, rdata;
   uscs_pkg::uscs_bus_req_t bus;
   uscs_pkg::uscs_mode_t mode;
   int err_total, cmp_count;
   uscs_top u_dut (.CLK_IN(clk), .RST_N_IN(rst_n), .BUS_IN(bus), .MODE_IN(mode),
      .DIV_K_IN(div_k), .COMPANION_TIMER_IN(tmr), .RXD_IN(rxd), .RDATA_OUT(rdata),
      .RVALID_OUT(rvalid), .WAIT_OUT(waitp), .TXD_OUT(txd));
   uscs_node u_node (.clk_in(clk), .txd_in(txd), .rxd_out(rxd));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Even duty square wave, a base tick every four clocks
   initial begin
      tmr = 1'b0;
      forever begin
         repeat (2) @(posedge clk);
         tmr <= ~tmr;
      end
   end
   function automatic logic par_bit(input logic [7:0] d, input logic [1:0] pm);
      return (pm == 2'b11) ? ^d : (pm == 2'b10) ? ~^d : 1'b0;
   endfunction
   function automatic logic [7:0] flags(input logic [1:0] pm, input logic bp,
         input logic bs, input logic ov);
      return {5'h00, bp & pm[1], bs, ov};
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: %s got %h want %h", $time, msg, got, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk) bus <= '{addr:a, rd:1'b0, wr:1'b1, wdata:d};
      @(posedge clk) bus <= '0;
   endtask
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      int n;
      logic w, e;
      n = 0;
      w = 1'b0;
      e = (a == 16'hff53);
      @(posedge clk) bus <= '{addr:a, rd:1'b1, wr:1'b0, wdata:8'h00};
      @(posedge clk) bus <= '0;
      do begin
         @(negedge clk);
         n++;
         w |= (waitp === 1'b1);
      end while (rvalid !== 1'b1 && n < 4);
      d = rdata;
      chk({w, 7'(n)}, {e, e ? 7'd2 : 7'd1}, "read timing");
   endtask
   task automatic rdchk(input logic [15:0] a, input logic [7:0] exp, input string msg);
      logic [7:0] d;
      rd(a, d);
      chk(d, exp, msg);
   endtask
   // Busy must read zero before the transmitter may be reinitialised
   task automatic tx_idle();
      logic [7:0] s;
      int n;
      n = 0;
      do begin
         rd(16'hff55, s);
         n++;
      end while (s !== 8'h00 && n < 400);
      chk(s, uscs_pkg::TX_STAT_RST, "tx idle");
   endtask
   // Clock select only changes while the unit is powered down
   task automatic set_mode(input logic [1:0] pm, input logic s2, input logic [3:0] code);
      @(posedge clk) mode <= '0;
      repeat (2) @(posedge clk);
      wr(16'hff56, {4'h0, code});
      mode <= '{power:1'b1, tx_en:1'b1, rx_en:1'b1, parity:uscs_pkg::uscs_par_t'(pm),
         char8:1'b1, stop2:s2};
      @(posedge clk);
   endtask
   task automatic rx_case(input logic [7:0] d, input logic [1:0] pm, input logic bp,
         input logic bs);
      u_node.send(d, pm != 2'b00, par_bit(d, pm) ^ bp, ~bs);
      repeat (4) @(posedge clk);
   endtask
   task automatic conclude();
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge clk);
      err_total++;
      $display("wrong value at %0t: watchdog expired", $time);
      conclude();
   end
   initial begin
      logic [7:0] a, b, g, h;
      logic [1:0] pm;
      logic bp, bs;
      int n, w, gap;
      err_total = 0;
      cmp_count = 0;
      rst_n = 1'b0;
      bus = '0;
      mode = '0;
      div_k = 8'h08;
      void'($urandom(11345));
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      rdchk(16'hff53, 8'h00, "err reset");
      rdchk(16'hff55, 8'h00, "tx reset");
      rdchk(16'hff56, 8'h00, "cks reset");
      rdchk(16'hff54, uscs_pkg::UNMAPPED_VAL, "unmapped");
      $display("test reset done");
      for (int c = 0; c < 16; c++) begin
         wr(16'hff56, 8'hf0 | 8'(c));
         rdchk(16'hff56, 8'(c), "cks rw");
      end
      $display("test clock select done");
      for (int i = 0; i < 8; i++) begin
         pm = 2'(i);
         bp = i[2];
         bs = i[0] & i[1];
         set_mode(pm, i[2], 4'h0);
         a = 8'($urandom);
         rx_case(a, pm, bp, bs);
         rdchk(16'hff53, flags(pm, bp, bs, 1'b0), "rx flags");
         rdchk(16'hff51, a, "rx data");
         rdchk(16'hff53, 8'h00, "clear on read");
      end
      set_mode(2'b11, 1'b0, 4'h0);
      a = 8'($urandom);
      b = 8'($urandom);
      rx_case(a, 2'b11, 1'b0, 1'b0);
      rx_case(b, 2'b11, 1'b0, 1'b0);
      rdchk(16'hff53, flags(2'b11, 1'b0, 1'b0, 1'b1), "overrun");
      rdchk(16'hff51, a, "old kept");
      rx_case(b, 2'b11, 1'b1, 1'b0);
      @(posedge clk) mode.rx_en <= 1'b0;
      @(posedge clk) mode.rx_en <= 1'b1;
      rdchk(16'hff53, 8'h00, "rx disable");
      rdchk(16'hff51, b, "buffer after disable");
      // Seven-bit character with even parity carried in the eighth data slot
      @(posedge clk) mode.char8 <= 1'b0;
      a = 8'($urandom);
      a[7] = ^a[6:0];
      rx_case(a, 2'b00, 1'b0, 1'b0);
      rdchk(16'hff53, 8'h00, "seven bit flags");
      rdchk(16'hff51, {1'b0, a[6:0]}, "seven bit data");
      $display("test receive done");
      for (int i = 0; i < 4; i++) begin
         set_mode(2'b00, 1'b0, (i == 3) ? 4'hb : 4'(i));
         wr(16'hff52, 8'h55);
         u_node.hi_width(w);
         chk(8'(w), (i == 3) ? 8'd64 : 8'(16 << i), "bit time");
         tx_idle();
      end
      $display("test bit rate done");
      set_mode(2'b00, 1'b0, 4'h0);
      a = 8'($urandom) | 8'h01;
      b = 8'($urandom) | 8'h01;
      fork
         begin
            u_node.recv(g, gap);
            chk(g, a, "first frame");
            chk({7'h0, gap <= 9}, 8'h01, "frame gap");
            u_node.recv(g, w);
            chk(g, b, "second frame");
         end
         begin
            wr(16'hff52, a);
            n = 0;
            do begin
               rd(16'hff55, h);
               n++;
            end while (h[1] !== 1'b0 && n < 50);
            wr(16'hff52, b);
            rdchk(16'hff55, 8'h03, "full and busy");
         end
      join
      tx_idle();
      // Seven-bit even-parity frame, two stop bits: parity lands in the eighth slot
      set_mode(2'b11, 1'b1, 4'h0);
      @(posedge clk) mode.char8 <= 1'b0;
      wr(16'hff52, a);
      u_node.recv(g, gap);
      chk(g, {par_bit({1'b0, a[6:0]}, 2'b11), a[6:0]}, "seven bit frame");
      tx_idle();
      wr(16'hff52, a);
      repeat (4) @(posedge clk);
      mode.tx_en <= 1'b0;
      @(posedge clk) mode.tx_en <= 1'b1;
      rdchk(16'hff55, 8'h00, "tx disable");
      $display("test transmit done");
      conclude();
   end
endmodule
`default_nettype wire
